// *** verilog/uefd_regs.svh ***
`ifndef UEFD_REGS_SVH
`define UEFD_REGS_SVH

// register byte addresses on the apb bus
`define UEFD_ADDR_STATUS 12'h000
`define UEFD_ADDR_EOD 12'h004
`define UEFD_ADDR_FIFO_CLR 12'h008

// data-present bit positions, shared by status and fifo clear registers
`define UEFD_BIT_BULK_OUT 4
`define UEFD_BIT_BULK_IN 2
`define UEFD_BIT_CTRL_TX 1
`define UEFD_BIT_CTRL_RX 0

// end-of-data control bit positions
`define UEFD_BIT_EOD_BULK_IN 0
`define UEFD_BIT_EOD_CTRL 1

// reset value of the status register
`define UEFD_STATUS_RESET 8'h00

// mask of implemented status bits
`define UEFD_STATUS_MASK 8'h17

// clocks from a fifo clear write to the status showing it
`define UEFD_CLR_LATENCY 5
// pipeline stages between the write edge and the flag update edge
`define UEFD_CLR_STAGES 4

`endif

// *** verilog/uefd_pkg.sv ***
`default_nettype none

package uefd_pkg;

    // apb slave states, one-hot
    typedef enum logic [2:0] {
        UEFD_ST_IDLE = 3'b001,
        UEFD_ST_RESP = 3'b010,
        UEFD_ST_SPARE = 3'b100
    } uefd_apb_state_e;

    // one byte of register data
    typedef logic [7:0] uefd_byte_t;

endpackage : uefd_pkg

`default_nettype wire

// *** verilog/uefd_clr_delay.sv ***
`timescale 1ns/1ps
`default_nettype none

// delays the fifo clear mask so the flags update a fixed time after the write
module uefd_clr_delay
    import uefd_pkg::*;
#(
    parameter int STAGES = 4,
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // mask in and delayed mask out
    input wire logic [WIDTH-1:0] i_mask,
    output logic [WIDTH-1:0] o_mask_q
);

    // shift stages, stage 0 takes the input
    logic [WIDTH-1:0] pipe_q [STAGES];
    logic [WIDTH-1:0] pipe_d [STAGES];

    // next values of each stage
    always_comb begin
        pipe_d[0] = i_mask;
        for (int k = 1; k < STAGES; k++) begin
            pipe_d[k] = pipe_q[k-1];
        end
    end

    // register the stages
    always_ff @(posedge i_sys_clk) begin
        for (int k = 0; k < STAGES; k++) begin
            if (i_rst) begin
                pipe_q[k] <= '0;
            end else begin
                pipe_q[k] <= pipe_d[k];
            end
        end
    end

    // last stage leaves from a register
    assign o_mask_q = pipe_q[STAGES-1];

endmodule // uefd_clr_delay

`default_nettype wire

// *** verilog/uefd_data_flags.sv ***
// Notes on behaviour
// - bulk-out toggle with data sets its flag
// - bulk-out counter reaching zero clears flag
// - null bulk-out packet sets nothing
// - bulk-in flag shows data, forceable by software
// - bulk-in end-of-data at zero count sets flag
// - bulk-in toggle clears its flag
// - control end-of-data sets transmit flag at once
// - transmit flag clears only after good transmission or a fifo clear
// - control receive counter zero clears receive flag
// - null control packet leaves receive flag clear
// - all flags read zero after reset
// - status is read-only byte, writes ignored
// - fifo clear shows in status five clocks later
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "uefd_regs.svh"
`default_nettype none

module uefd_data_flags
    import uefd_pkg::*;
#(
    parameter int CNT_W = 7
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata_q,
    output logic o_pready_q,
    output logic o_pslverr_q,
    // bulk-out fifo events
    input wire logic i_bo_toggle,
    input wire logic i_bo_null_rx,
    input wire logic [CNT_W-1:0] i_bo_count,
    // bulk-in fifo events
    input wire logic i_bi_toggle,
    input wire logic [CNT_W-1:0] i_bi_count,
    // control transmit fifo events
    input wire logic i_ctx_tx_ok,
    input wire logic [CNT_W-1:0] i_ctx_count,
    // control receive fifo events
    input wire logic i_crx_rx_done,
    input wire logic i_crx_null,
    input wire logic [CNT_W-1:0] i_crx_count,
    // pulses to the fifos
    output logic o_bi_eod_q,
    output logic o_ctx_eod_q,
    output logic [7:0] o_fifo_clr_q
);

    // counter went from nonzero to zero
    function automatic logic fell_to_zero(input logic [CNT_W-1:0] prev,
                                          input logic [CNT_W-1:0] cur);
        fell_to_zero = (prev != '0) && (cur == '0);
    endfunction

    // counter went from zero to nonzero
    function automatic logic rose_from_zero(input logic [CNT_W-1:0] prev,
                                            input logic [CNT_W-1:0] cur);
        rose_from_zero = (prev == '0) && (cur != '0);
    endfunction

    // apb state and answer registers
    uefd_apb_state_e st_q, st_d;
    logic [31:0] prdata_d;
    logic pready_d;
    logic pslverr_d;
    // strobes of the current access
    logic wr_acc; // write taken at this edge
    logic eod_wr; // write to end-of-data register
    logic clr_wr; // write to fifo clear register
    uefd_byte_t clr_mask_c; // implemented bits of the clear write
    // data-present flags
    logic bo_q, bo_d;
    logic bi_q, bi_d;
    logic ctx_q, ctx_d;
    logic crx_q, crx_d;
    // previous counter values
    logic [CNT_W-1:0] bo_cnt_q, bi_cnt_q, ctx_cnt_q, crx_cnt_q;
    // set and clear terms of each flag
    logic bo_set, bo_clr, bi_set, bi_clr, ctx_set, ctx_clr, crx_set, crx_clr;
    // delayed fifo clear mask
    logic [7:0] clr_apply;
    // pulses to fifos
    logic bi_eod_d, ctx_eod_d;
    logic [7:0] fifo_clr_d;
    // assembled status byte
    uefd_byte_t status_c;

    // the write lands at the edge where the master sees pready high
    assign wr_acc = (st_q == UEFD_ST_RESP) && i_psel && i_penable && i_pwrite;
    assign eod_wr = wr_acc && (i_paddr == `UEFD_ADDR_EOD);
    assign clr_wr = wr_acc && (i_paddr == `UEFD_ADDR_FIFO_CLR);
    assign clr_mask_c = clr_wr ? (i_pwdata[7:0] & `UEFD_STATUS_MASK) : 8'h00;

    // status byte with unused bits tied to zero
    always_comb begin
        status_c = `UEFD_STATUS_RESET;
        status_c[`UEFD_BIT_BULK_OUT] = bo_q;
        status_c[`UEFD_BIT_BULK_IN] = bi_q;
        status_c[`UEFD_BIT_CTRL_TX] = ctx_q;
        status_c[`UEFD_BIT_CTRL_RX] = crx_q;
    end

    // apb next state, one wait state then the answer
    always_comb begin
        st_d = st_q;
        prdata_d = 32'h0000_0000;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        case (st_q)
            // access seen: answer next cycle
            UEFD_ST_IDLE: begin
                if (i_psel && i_penable) begin
                    st_d = UEFD_ST_RESP;
                    pready_d = 1'b1;
                    case (i_paddr)
                        // status read is byte wide, write ignored
                        `UEFD_ADDR_STATUS: begin
                            prdata_d = {24'h00_0000, status_c};
                        end
                        // self-clearing controls read back zero
                        `UEFD_ADDR_EOD, `UEFD_ADDR_FIFO_CLR: begin
                            prdata_d = 32'h0000_0000;
                        end
                        // unmapped address answers with an error
                        default: begin
                            pslverr_d = 1'b1;
                        end
                    endcase
                end
            end
            // answer shown: transfer ends at this edge
            UEFD_ST_RESP: begin
                st_d = UEFD_ST_IDLE;
            end
            // unused code falls back to idle
            default: begin
                st_d = UEFD_ST_IDLE;
            end
        endcase
    end

    // apb registers
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            st_q <= UEFD_ST_IDLE;
            o_prdata_q <= 32'h0000_0000;
            o_pready_q <= 1'b0;
            o_pslverr_q <= 1'b0;
        end else begin
            st_q <= st_d;
            o_prdata_q <= prdata_d;
            o_pready_q <= pready_d;
            o_pslverr_q <= pslverr_d;
        end
    end

    // clear mask held back so the status updates after the fixed latency
    uefd_clr_delay #(
        .STAGES(`UEFD_CLR_STAGES),
        .WIDTH(8)
    ) u_clr_delay (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_mask(clr_mask_c),
        .o_mask_q(clr_apply)
    );

    // set and clear terms; a set in the clear cycle wins
    always_comb begin
        bo_set = i_bo_toggle && !i_bo_null_rx;
        bo_clr = fell_to_zero(bo_cnt_q, i_bo_count)
            || clr_apply[`UEFD_BIT_BULK_OUT];
        bi_set = (eod_wr && i_pwdata[`UEFD_BIT_EOD_BULK_IN] && (i_bi_count == '0))
            || rose_from_zero(bi_cnt_q, i_bi_count);
        bi_clr = i_bi_toggle || clr_apply[`UEFD_BIT_BULK_IN];
        ctx_set = (eod_wr && i_pwdata[`UEFD_BIT_EOD_CTRL])
            || rose_from_zero(ctx_cnt_q, i_ctx_count);
        ctx_clr = i_ctx_tx_ok || clr_apply[`UEFD_BIT_CTRL_TX];
        crx_set = i_crx_rx_done && !i_crx_null;
        crx_clr = fell_to_zero(crx_cnt_q, i_crx_count)
            || clr_apply[`UEFD_BIT_CTRL_RX];
        bo_d = bo_set || (bo_q && !bo_clr);
        bi_d = bi_set || (bi_q && !bi_clr);
        ctx_d = ctx_set || (ctx_q && !ctx_clr);
        crx_d = crx_set || (crx_q && !crx_clr);
    end

    // flags and counter history
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            bo_q <= 1'b0;
            bi_q <= 1'b0;
            ctx_q <= 1'b0;
            crx_q <= 1'b0;
            bo_cnt_q <= '0;
            bi_cnt_q <= '0;
            ctx_cnt_q <= '0;
            crx_cnt_q <= '0;
        end else begin
            bo_q <= bo_d;
            bi_q <= bi_d;
            ctx_q <= ctx_d;
            crx_q <= crx_d;
            bo_cnt_q <= i_bo_count;
            bi_cnt_q <= i_bi_count;
            ctx_cnt_q <= i_ctx_count;
            crx_cnt_q <= i_crx_count;
        end
    end

    // pulses to the fifos on control writes
    always_comb begin
        bi_eod_d = eod_wr && i_pwdata[`UEFD_BIT_EOD_BULK_IN];
        ctx_eod_d = eod_wr && i_pwdata[`UEFD_BIT_EOD_CTRL];
        fifo_clr_d = clr_mask_c;
    end

    // pulse registers
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_bi_eod_q <= 1'b0;
            o_ctx_eod_q <= 1'b0;
            o_fifo_clr_q <= 8'h00;
        end else begin
            o_bi_eod_q <= bi_eod_d;
            o_ctx_eod_q <= ctx_eod_d;
            o_fifo_clr_q <= fifo_clr_d;
        end
    end

    // bulk-out toggle with data shows next cycle
    AST_BO_SET: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_bo_toggle && !i_bo_null_rx) |=> bo_q)
        else $error("bulk-out flag not set after toggle");

    // bulk-out counter reaching zero clears the flag
    AST_BO_CLR: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (bo_q && fell_to_zero(bo_cnt_q, i_bo_count) && !i_bo_toggle) |=> !bo_q)
        else $error("bulk-out flag not cleared at zero count");

    // null bulk-out packet never raises the flag
    AST_BO_NULL: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (!bo_q && i_bo_null_rx) |=> !bo_q)
        else $error("bulk-out flag set by null packet");

    // bulk-in end-of-data at zero count sets the flag and pulses o_bi_eod_q
    AST_BI_EOD: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (eod_wr && i_pwdata[`UEFD_BIT_EOD_BULK_IN] && i_bi_count == '0)
        |=> bi_q && o_bi_eod_q)
        else $error("bulk-in flag not set by end-of-data");

    // bulk-in toggle clears the flag
    AST_BI_CLR: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_bi_toggle && !bi_set) |=> !bi_q)
        else $error("bulk-in flag not cleared by toggle");

    // control end-of-data sets the transmit flag regardless of count
    AST_CTX_SET: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (eod_wr && i_pwdata[`UEFD_BIT_EOD_CTRL]) |=> ctx_q)
        else $error("control transmit flag not set");

    // transmit flag stays until good transmission or fifo clear
    AST_CTX_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (ctx_q && !i_ctx_tx_ok && !clr_apply[`UEFD_BIT_CTRL_TX]) |=> ctx_q)
        else $error("control transmit flag dropped early");

    // receive flag clears when the counter drains
    AST_CRX_CLR: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (crx_q && fell_to_zero(crx_cnt_q, i_crx_count) && !crx_set) |=> !crx_q)
        else $error("control receive flag not cleared");

    // null control packet leaves a clear receive flag clear
    AST_CRX_NULL: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (!crx_q && i_crx_rx_done && i_crx_null) |=> !crx_q)
        else $error("control receive flag set by null packet");

    // reset empties every flag
    AST_RST_EMPTY: assert property (@(posedge i_sys_clk)
        i_rst |=> (status_c == `UEFD_STATUS_RESET))
        else $error("flags not zero after reset");

    // status write raises no fifo clear pulse and no bulk-in end-of-data pulse
    AST_RO_WRITE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (wr_acc && i_paddr == `UEFD_ADDR_STATUS) |=> (o_fifo_clr_q == 8'h00 && !o_bi_eod_q))
        else $error("status write had an effect");

    // clear mask reaches the flags four edges after the write edge
    AST_CLR_LAT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        clr_wr |-> ##4 (clr_apply == $past(clr_mask_c, 4)))
        else $error("fifo clear latency wrong");

    // read answers carry zero in all unused bits
    AST_RD_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_pready_q |-> (o_prdata_q[31:8] == 24'h00_0000 && o_prdata_q[7:5] == 3'b000
            && o_prdata_q[3] == 1'b0))
        else $error("unused status bits not zero");

    // bulk-out flag holds until its counter drains or a clear lands
    AST_BO_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (bo_q && !fell_to_zero(bo_cnt_q, i_bo_count) && !clr_apply[`UEFD_BIT_BULK_OUT])
        |=> bo_q)
        else $error("bulk-out flag dropped early");

    // bulk-in fill from an empty fifo raises the flag
    AST_BI_FILL: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        rose_from_zero(bi_cnt_q, i_bi_count) |=> bi_q)
        else $error("bulk-in flag not set by fill");

    // good transmission clears the transmit flag unless a set lands too
    AST_CTX_CLR: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_ctx_tx_ok && !ctx_set) |=> !ctx_q)
        else $error("control transmit flag not cleared");

    // control packet with data raises the receive flag
    AST_CRX_SET: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_crx_rx_done && !i_crx_null) |=> crx_q)
        else $error("control receive flag not set");

    // status read answer carries the flags of the access edge
    AST_RD_STATUS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (st_q == UEFD_ST_IDLE && i_psel && i_penable && i_paddr == `UEFD_ADDR_STATUS)
        |=> (o_prdata_q[7:0] == $past(status_c)))
        else $error("status read data wrong");

    // pready stands a single cycle per transfer
    AST_RDY_ONE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_pready_q |=> !o_pready_q)
        else $error("pready held too long");

    // error answer only comes with pready
    AST_ERR_RDY: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_pslverr_q |-> o_pready_q)
        else $error("pslverr without pready");

endmodule // uefd_data_flags

`default_nettype wire

// *** verilog/uefd_pkg_end.sv ***
`default_nettype none
`default_nettype wire

// *** verif/uefd_fifo_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// far-side model: usb engine and fifo counters feeding the flag logic
module uefd_fifo_model #(
    parameter int CNT_W = 7
) (
    // clock
    input wire logic i_sys_clk,
    // bulk-out fifo
    output logic o_bo_toggle = 1'h0,
    output logic o_bo_null_rx = 1'h0,
    output logic [CNT_W-1:0] o_bo_count = '0,
    // bulk-in fifo
    output logic o_bi_toggle = 1'h0,
    output logic [CNT_W-1:0] o_bi_count = '0,
    // control transmit fifo
    output logic o_ctx_tx_ok = 1'h0,
    output logic [CNT_W-1:0] o_ctx_count = '0,
    // control receive fifo
    output logic o_crx_rx_done = 1'h0,
    output logic o_crx_null = 1'h0,
    output logic [CNT_W-1:0] o_crx_count = '0
);
    // bulk-out packet arrives; a null packet leaves the count alone
    task automatic bo_rx(input logic [CNT_W-1:0] n);
        @(posedge i_sys_clk);
        o_bo_toggle <= 1'h1;
        o_bo_null_rx <= (n == '0);
        o_bo_count <= (n == '0) ? o_bo_count : n;
        @(posedge i_sys_clk);
        o_bo_toggle <= 1'h0;
        o_bo_null_rx <= 1'h0;
    endtask
    // control packet arrives; same null handling as bulk-out
    task automatic crx_rx(input logic [CNT_W-1:0] n);
        @(posedge i_sys_clk);
        o_crx_rx_done <= 1'h1;
        o_crx_null <= (n == '0);
        o_crx_count <= (n == '0) ? o_crx_count : n;
        @(posedge i_sys_clk);
        o_crx_rx_done <= 1'h0;
        o_crx_null <= 1'h0;
    endtask
    // cpu reads one byte per clock; local copy avoids stale nba reads
    task automatic drain(input logic rx_ctrl);
        int c;
        c = rx_ctrl ? int'(o_crx_count) : int'(o_bo_count);
        while (c > 0) begin
            @(posedge i_sys_clk);
            c--;
            if (rx_ctrl) begin
                o_crx_count <= CNT_W'(c);
            end else begin
                o_bo_count <= CNT_W'(c);
            end
        end
    endtask
    // cpu writes bytes into a transmit fifo
    task automatic fill(input logic ctrl, input logic [CNT_W-1:0] n);
        @(posedge i_sys_clk);
        if (ctrl) begin
            o_ctx_count <= n;
        end else begin
            o_bi_count <= n;
        end
    endtask
    // transmit fifo handed to the usb side, count back to zero
    task automatic send(input logic ctrl);
        @(posedge i_sys_clk);
        o_bi_toggle <= !ctrl;
        o_ctx_tx_ok <= ctrl;
        if (ctrl) begin
            o_ctx_count <= '0;
        end else begin
            o_bi_count <= '0;
        end
        @(posedge i_sys_clk);
        o_bi_toggle <= 1'h0;
        o_ctx_tx_ok <= 1'h0;
    endtask
endmodule // uefd_fifo_model

`default_nettype wire

// *** verif/uefd_data_flags_tb.sv ***
`timescale 1ns/1ps
`include "uefd_regs.svh"
`default_nettype none

// self-checking bench for the endpoint data-present flags
module uefd_data_flags_tb;
    import uefd_pkg::*;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, bo_tg, bo_nl, bi_tg, ctx_ok, crx_dn, crx_nl, bi_eod, ctx_eod;
    logic [6:0] bo_cnt, bi_cnt, ctx_cnt, crx_cnt;
    logic [7:0] clr;
    int bad_count = 0;
    int checks = 0;
    // expected flags and last bus answer
    logic e_bo = 1'h0, e_bi = 1'h0, e_ctx = 1'h0, e_crx = 1'h0, err;
    logic [31:0] rd;
    int dop[$] = '{7, 0, 11, 10, 2, 2, 3, 6, 3, 4, 5, 12, 4, 5, 0, 1, 7, 8, 0, 2, 4, 7, 9};
    int dn[$] = '{0, 0, 0, 255, 0, 0, 0, 1, 0, 0, 0, 127, 0, 0, 127, 0, 1, 0, 3, 0, 0, 2, 23};
    // empties every fifo, then forces the two transmit flags
    int mop[6] = '{3, 5, 1, 8, 2, 4};

    // free-running system clock
    always #4 clk = ~clk;

    uefd_data_flags dut (.i_sys_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata_q(prdata),
        .o_pready_q(pready), .o_pslverr_q(pslverr), .i_bo_toggle(bo_tg), .i_bo_null_rx(bo_nl),
        .i_bo_count(bo_cnt), .i_bi_toggle(bi_tg), .i_bi_count(bi_cnt), .i_ctx_tx_ok(ctx_ok),
        .i_ctx_count(ctx_cnt), .i_crx_rx_done(crx_dn), .i_crx_null(crx_nl),
        .i_crx_count(crx_cnt), .o_bi_eod_q(bi_eod), .o_ctx_eod_q(ctx_eod), .o_fifo_clr_q(clr));

    uefd_fifo_model pm (.i_sys_clk(clk), .o_bo_toggle(bo_tg), .o_bo_null_rx(bo_nl),
        .o_bo_count(bo_cnt), .o_bi_toggle(bi_tg), .o_bi_count(bi_cnt), .o_ctx_tx_ok(ctx_ok),
        .o_ctx_count(ctx_cnt), .o_crx_rx_done(crx_dn), .o_crx_null(crx_nl),
        .o_crx_count(crx_cnt));

    // status byte as the flags should show it, other bits zero
    function automatic logic [31:0] exp_status(input logic bo, bi, ctx, crx);
        return {24'h000000, 3'h0, bo, 1'h0, bi, ctx, crx};
    endfunction

    // count and report one comparison
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        // wait for the answer; only the watchdog ends a hung wait
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // read the status register and compare it with the expected flags
    task automatic read_status;
        apb(1'h0, `UEFD_ADDR_STATUS, 32'h00000000);
        chk("status", exp_status(e_bo, e_bi, e_ctx, e_crx), rd);
        chk("status error", 32'h00000000, {31'h0, err});
    endtask

    // one operation: expectation first (after the write for a fifo clear), then stimulus, then a status read
    task automatic do_op(input int op, input int n);
        case (op)
            0, 7: begin
                if (n % 128 != 0 && op == 0) e_bo = 1'h1;
                if (n % 128 != 0 && op == 7) e_crx = 1'h1;
                if (op == 0) pm.bo_rx(7'(n)); else pm.crx_rx(7'(n));
            end
            1, 8: begin
                if (op == 1 && bo_cnt != 7'h00) e_bo = 1'h0;
                if (op == 8 && crx_cnt != 7'h00) e_crx = 1'h0;
                pm.drain(op == 8);
            end
            2, 4: begin
                if (op == 2 && bi_cnt == 7'h00) e_bi = 1'h1;
                if (op == 4) e_ctx = 1'h1;
                apb(1'h1, `UEFD_ADDR_EOD, (op == 2) ? 32'h1 : 32'h2);
                @(negedge clk);
                chk("eod pulse", (op == 2) ? 32'h1 : 32'h2, {30'h0, ctx_eod, bi_eod});
            end
            3, 5: begin
                if (op == 3) e_bi = 1'h0; else e_ctx = 1'h0;
                pm.send(op == 5);
            end
            6, 12: begin
                if (op == 6 && bi_cnt == 7'h00) e_bi = 1'h1;
                if (op == 12 && ctx_cnt == 7'h00) e_ctx = 1'h1;
                pm.fill(op == 12, 7'(n % 127 + 1));
            end
            9: begin
                apb(1'h1, `UEFD_ADDR_FIFO_CLR, 32'(n & 8'h17));
                @(negedge clk);
                chk("clear pulse", 32'(n & 8'h17), {24'h0, clr});
                e_bo &= !n[4];
                e_bi &= !n[2];
                e_ctx &= !n[1];
                e_crx &= !n[0];
                repeat (4) @(posedge clk);
            end
            10: apb(1'h1, `UEFD_ADDR_STATUS, 32'(n));
            default: begin
                apb(1'h0, 12'h0fc, 32'h0);
                chk("unmapped", 32'h1, {31'h0, err});
                chk("unmapped data", 32'h0, rd);
            end
        endcase
        read_status();
    endtask

    // verdict and end of run
    task automatic end_sim;
        if (bad_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        repeat (30000) @(posedge clk);
        bad_count++;
        end_sim();
    end

    // reset, directed corner cases, then random traffic
    initial begin
        void'($urandom(32'h2c6997d3));
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        read_status();
        foreach (dop[i]) begin
            do_op(dop[i], dn[i]);
        end
        // empty every fifo, raise the two forced flags, then reset mid-run
        foreach (mop[i]) begin
            do_op(mop[i], 0);
        end
        @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        {e_bo, e_bi, e_ctx, e_crx} = 4'h0;
        read_status();
        repeat (150) begin
            do_op($urandom_range(0, 12), $urandom_range(0, 127));
        end
        end_sim();
    end
endmodule // uefd_data_flags_tb

`default_nettype wire
